//--- design/irr_pkg.sv
package irr_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] IRR_IDX_CTRL   = 16'h7f96;  // Run, format and base clock.
    localparam logic [15:0] IRR_IDX_STATUS = 16'h7f97;  // Sticky event flags.
    localparam logic [15:0] IRR_IDX_SHIFT  = 16'h7f98;  // Receive shift register.
    localparam logic [15:0] IRR_IDX_DATA   = 16'h7f99;  // Receive data register.
    localparam logic [15:0] IRR_IDX_CNTPR  = 16'h7f9a;  // Bit counter and prescale select.
    localparam logic [15:0] IRR_IDX_GUIDE  = 16'h7f9b;  // Guide width register.
    localparam logic [15:0] IRR_IDX_DATA0  = 16'h7f9c;  // Data-0 width register.
    localparam logic [15:0] IRR_IDX_DATA1  = 16'h7f9d;  // Data-1 width register.
    localparam logic [15:0] IRR_IDX_HIGH   = 16'h7f9e;  // Pulse width high bits.

    // Control register fields.
    localparam int IRR_CTRL_RUN     = 0;
    localparam int IRR_CTRL_FMT_LO  = 1;
    localparam int IRR_CTRL_CK_LO   = 4;

    // Status register fields.
    localparam int IRR_ST_END       = 0;
    localparam int IRR_ST_FULL      = 1;
    localparam int IRR_ST_DATA_ERROR_FLAG      = 2;
    localparam int IRR_ST_GOK       = 3;

    // Pulse width high bits fields.
    localparam int IRR_HB_DIR       = 7;
    localparam int IRR_HB_D1H       = 5;
    localparam int IRR_HB_D1L       = 4;
    localparam int IRR_HB_D0H       = 3;
    localparam int IRR_HB_D0L       = 2;
    localparam int IRR_HB_GH        = 1;
    localparam int IRR_HB_GL        = 0;

    // Counter and prescale register fields.
    localparam int IRR_CP_GPR_LO    = 6;
    localparam int IRR_CP_DPR_LO    = 4;
    localparam int IRR_CP_HOLD      = 3;

    // Value after reset and majority counter limit.
    localparam logic [7:0] IRR_RST_REG  = 8'h00;
    localparam logic [5:0] IRR_CNT_MAX  = 6'h3f;

    // Receive formats.
    localparam logic [1:0] IRR_FMT_A = 2'h0;
    localparam logic [1:0] IRR_FMT_B = 2'h1;
    localparam logic [1:0] IRR_FMT_C = 2'h2;

    // Receiver sequence.
    typedef enum logic [1:0] {
        IRR_IDLE,
        IRR_GUIDE,
        IRR_DATA,
        IRR_HOLD
    } irr_state_t;

endpackage

//--- design/irr_receiver.sv
`timescale 1ns/100ps
module irr_receiver
    import irr_pkg::*;
#(
    parameter int ADR_W = 18                    // Byte address width on the bus.
) (
    input  wire logic             clk_i,        // System clock, 250 MHz.
    input  wire logic             rst_i,        // Synchronous reset, active high.
    input  wire logic             cyc_i,        // Wishbone cycle.
    input  wire logic             stb_i,        // Wishbone strobe.
    input  wire logic             we_i,         // Wishbone write enable.
    input  wire logic [ADR_W-1:0] adr_i,        // Wishbone byte address.
    input  wire logic [3:0]       sel_i,        // Wishbone byte selects.
    input  wire logic [31:0]      dat_i,        // Wishbone write data.
    output logic      [31:0]      dat_o,        // Wishbone read data.
    output logic                  ack_o,        // Wishbone acknowledge.
    input  wire logic             remote_i      // Demodulated remote input.
);

    // Software visible registers.
    logic [7:0]  ctrl_q;                        // Run, format, base clock select.
    logic [7:0]  high_q;                        // Pulse width high bits.
    logic [7:0]  guide_w_q;                     // Guide width register.
    logic [7:0]  data0_w_q;                     // Data-0 width register.
    logic [7:0]  data1_w_q;                     // Data-1 width register.
    logic [3:0]  presc_sel_q;                   // Guide and data prescale selects.
    logic [7:0]  shift_q;                       // Receive shift register.
    logic [7:0]  rx_data_q;                     // Receive data register.
    logic [2:0]  bit_cnt_q;                     // Received bit counter.
    logic        hold_q;                        // Suspend flag.
    logic        guide_ok_q;                    // Guide accepted flag.
    logic        data_err_q;                    // Data error flag.
    logic        full_q;                        // Byte full flag.
    logic        end_q;                         // End of reception flag.

    // Receiver state.
    irr_state_t  state_q;                       // Sequence state.
    logic [2:0]  sync_q;                        // Two synchroniser stages and one history.
    logic [7:0]  base_q;                        // Base clock divider.
    logic [4:0]  pre_q;                         // Measurement prescaler.
    logic [5:0]  mj_q;                          // Majority counter, width in units.

    // Bus decode.
    logic [15:0] idx;                           // Register index.
    logic        req;                           // New request this cycle.
    logic        wr;                            // Accepted write.
    logic        rd_shift;                      // Accepted read of the shift register.

    // Address bits 1:0 pick a lane and are ignored.
    // Ack masks req, so a held request is taken once.
    // All registers sit in lane 0; writes need sel_i[0].
    assign idx      = 16'(adr_i[ADR_W-1:2]);
    assign req      = cyc_i & stb_i & ~ack_o;
    assign wr       = req & we_i & sel_i[0];
    assign rd_shift = req & ~we_i & (idx == IRR_IDX_SHIFT);

    // Control fields.
    // Format 3 starts nothing; the receiver idles.
    // Each base select step doubles the unit.
    logic        run;
    logic [1:0]  fmt;
    logic [2:0]  ck_sel;
    assign run    = ctrl_q[IRR_CTRL_RUN];
    assign fmt    = ctrl_q[IRR_CTRL_FMT_LO +: 2];
    assign ck_sel = ctrl_q[IRR_CTRL_CK_LO +: 3];


    // A bound is a top bit over a width nibble.
    // Window order is up to software and is not checked;
    // a pulse in two windows decodes as a zero.
    // data-1, data-0 and guide bounds
    logic [4:0]  d1_hi, d1_lo, d0_hi, d0_lo, g_hi, g_lo;
    assign d1_hi = {high_q[IRR_HB_D1H], data1_w_q[7:4]};
    assign d1_lo = {high_q[IRR_HB_D1L], data1_w_q[3:0]};
    assign d0_hi = {high_q[IRR_HB_D0H], data0_w_q[7:4]};
    assign d0_lo = {high_q[IRR_HB_D0L], data0_w_q[3:0]};
    assign g_hi  = {high_q[IRR_HB_GH], guide_w_q[7:4]};
    assign g_lo  = {high_q[IRR_HB_GL], guide_w_q[3:0]};


    // Edges are taken from the second synchroniser stage and the history stage only.
    // Both ends of a width see the same delay,
    // so latency does not bias the width.
    logic        rise, fall;
    assign rise = sync_q[1] & ~sync_q[2];
    assign fall = ~sync_q[1] & sync_q[2];

    // The format A guide is high, so it ends on a fall.
    // format A ends guide and data on falls, B and C on rises
    logic        meas_edge;
    assign meas_edge = (fmt == IRR_FMT_A) ? fall : rise;

    // Width within [lower+1, upper+1) means mj > lower and mj <= upper.
    // The count holds whole units since the last edge,
    // so no adder is needed for the plus one.
    function automatic logic in_win(input logic [5:0] w, input logic [4:0] lo,
                                    input logic [4:0] hi);
        in_win = (w > {1'b0, lo}) && (w <= {1'b0, hi});
    endfunction

    logic        guide_good;
    assign guide_good = in_win(mj_q, g_lo, g_hi);
    logic        is_zero;
    assign is_zero = in_win(mj_q, d0_lo, d0_hi);
    logic        is_one;
    assign is_one = in_win(mj_q, d1_lo, d1_hi);
    logic        overflow;
    assign overflow = (mj_q > {1'b0, d1_hi});


    // The data count starts at the guide's end.
    // guide count while measuring the guide
    logic [1:0]  psel;
    logic [4:0]  pre_last;
    assign psel = (state_q == IRR_GUIDE) ? presc_sel_q[3:2] : presc_sel_q[1:0];
    // codes 0..3 give 4, 8, 16, 32
    assign pre_last = 5'((6'h04 << psel) - 6'h01);


    // Base tick every 2^ck_sel clocks, unit tick after pre_last+1 base ticks.
    // Units are whole base ticks, so widths stay exact
    // at any base clock select.
    logic [7:0]  base_last;
    logic        base_tick, unit_tick;
    assign base_last = 8'((9'h001 << ck_sel) - 9'h001);
    assign base_tick = (base_q == base_last);
    assign unit_tick = base_tick & (pre_q == pre_last);


    // Events of the sequence this cycle.
    // An edge beats an overflow in the same cycle;
    // the pulse is then judged, not taken as the end.
    logic        start_edge;                    // Rise that starts a guide or a C frame.
    logic        guide_done;                    // Guide accepted.
    logic        bit_ok;                        // Valid data bit.
    logic        bit_bad;                       // Out-of-window data pulse.
    logic        rx_end;                        // End of reception.
    logic        restart;                       // Measurement restarts from this edge.
    assign start_edge = (state_q == IRR_IDLE) & rise;
    assign guide_done = (state_q == IRR_GUIDE) & meas_edge & guide_good;
    assign bit_ok     = (state_q == IRR_DATA) & meas_edge & (is_zero | is_one);
    assign bit_bad    = (state_q == IRR_DATA) & meas_edge & ~(is_zero | is_one);
    assign rx_end     = (state_q == IRR_DATA) & ~meas_edge & overflow;
    assign restart    = start_edge | ((state_q == IRR_GUIDE) & meas_edge) | bit_ok;


    // Input synchroniser; the first stage feeds only the second.
    // All stages reset low, the idle level of the
    // line, so no false rise follows reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], remote_i};
        end
    end


    // Wishbone answer one cycle after the request; unmapped reads return zero.
    // Read data stays put until the next read.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= req;
            if (req && !we_i) begin
                case (idx)
                    IRR_IDX_CTRL:   dat_o <= {24'h0, ctrl_q};
                    IRR_IDX_STATUS: dat_o <= {28'h0, guide_ok_q, data_err_q, full_q, end_q};
                    IRR_IDX_SHIFT:  dat_o <= {24'h0, shift_q};
                    IRR_IDX_DATA:   dat_o <= {24'h0, rx_data_q};
                    IRR_IDX_CNTPR:  dat_o <= {24'h0, presc_sel_q, hold_q, bit_cnt_q};
                    IRR_IDX_GUIDE:  dat_o <= {24'h0, guide_w_q};
                    IRR_IDX_DATA0:  dat_o <= {24'h0, data0_w_q};
                    IRR_IDX_DATA1:  dat_o <= {24'h0, data1_w_q};
                    // Bit 6 is not implemented and reads as zero.
                    IRR_IDX_HIGH:   dat_o <= {24'h0, high_q & 8'hbf};
                    default:        dat_o <= 32'h0;
                endcase
            end
        end
    end


    // Configuration registers written by software.
    // Windows should only change while run is clear;
    // a change mid-frame hits the next compare.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q      <= IRR_RST_REG;
            high_q      <= IRR_RST_REG;
            guide_w_q   <= IRR_RST_REG;
            data0_w_q   <= IRR_RST_REG;
            data1_w_q   <= IRR_RST_REG;
            presc_sel_q <= 4'h0;
        end else if (wr) begin
            case (idx)
                IRR_IDX_CTRL:  ctrl_q      <= dat_i[7:0];
                IRR_IDX_HIGH:  high_q      <= dat_i[7:0] & 8'hbf;
                IRR_IDX_GUIDE: guide_w_q   <= dat_i[7:0];
                IRR_IDX_DATA0: data0_w_q   <= dat_i[7:0];
                IRR_IDX_DATA1: data1_w_q   <= dat_i[7:0];
                IRR_IDX_CNTPR: presc_sel_q <= dat_i[7:4];
                default: begin
                end
            endcase
        end
    end


    // Sticky flags: an event in the same cycle as a write-one clear wins.
    // Write one to clear lets software clear one flag
    // with no race against the others.
    logic        clr_st;
    assign clr_st = wr & (idx == IRR_IDX_STATUS);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            guide_ok_q <= 1'b0;
            data_err_q <= 1'b0;
            full_q     <= 1'b0;
            end_q      <= 1'b0;
        end else begin
            guide_ok_q <= guide_done | (guide_ok_q & ~(clr_st & dat_i[IRR_ST_GOK]));
            data_err_q <= bit_bad | (data_err_q & ~(clr_st & dat_i[IRR_ST_DATA_ERROR_FLAG]));
            full_q     <= (bit_ok & (bit_cnt_q == 3'h7))
                        | (full_q & ~(clr_st & dat_i[IRR_ST_FULL]));
            end_q      <= rx_end | (end_q & ~(clr_st & dat_i[IRR_ST_END]));
        end
    end


    // Receive sequence; stopping the run returns state and hold to idle; the sticky flags and data register keep their values.
    // Hold keeps the last bits until software reads.
    always_ff @(posedge clk_i) begin
        if (rst_i || !run) begin
            state_q <= IRR_IDLE;
            hold_q  <= 1'b0;
        end else begin
            case (state_q)
                IRR_IDLE: begin
                    // format C goes straight to data
                    // only A and B expect a guide
                    if (rise && fmt == IRR_FMT_C) begin
                        state_q <= IRR_DATA;
                    end else if (rise && (fmt == IRR_FMT_A || fmt == IRR_FMT_B)) begin
                        state_q <= IRR_GUIDE;
                    end
                end
                IRR_GUIDE: begin
                    // A rejected guide simply waits for the next one.
                    if (meas_edge) begin
                        state_q <= guide_good ? IRR_DATA : IRR_IDLE;
                    end
                end
                IRR_DATA: begin
                    // error returns to idle for all formats
                    if (bit_bad) begin
                        state_q <= IRR_IDLE;
                    end else if (rx_end) begin
                        // suspend until shift register is read
                        state_q <= IRR_HOLD;
                        hold_q  <= 1'b1;
                    end
                end
                IRR_HOLD: begin
                    // resume waits for a new rise
                    if (rd_shift) begin
                        state_q <= IRR_IDLE;
                        hold_q  <= 1'b0;
                    end
                end
                default: state_q <= IRR_IDLE;
            endcase
        end
    end


    // Prescaler and majority counter restart at the start rise, at the guide's end and at each valid data bit.
    always_ff @(posedge clk_i) begin
        if (rst_i || !run) begin
            base_q <= 8'h0;
            pre_q  <= 5'h0;
            mj_q   <= 6'h0;
        end else if (restart) begin
            // The edge cycle is the width's first clock;
            // zero here would read each width one short.
            base_q <= (base_last == 8'h0) ? 8'h0 : 8'h01;
            pre_q  <= (base_last == 8'h0) ? 5'h01 : 5'h0;
            mj_q   <= 6'h0;
        end else if (state_q == IRR_IDLE || state_q == IRR_HOLD) begin
            // Nothing is measured while idle or held.
            base_q <= 8'h0;
            pre_q  <= 5'h0;
            mj_q   <= 6'h0;
        end else begin
            base_q <= base_tick ? 8'h0 : base_q + 8'h01;
            if (base_tick) begin
                pre_q <= (pre_q == pre_last) ? 5'h0 : pre_q + 5'h01;
            end
            // Saturates so a long pulse never wraps back into a window.
            if (unit_tick && mj_q != IRR_CNT_MAX) begin
                mj_q <= mj_q + 6'h01;
            end
        end
    end


    // Shift register, bit counter and data register.
    // The counter wraps at eight; after a frame it
    // gives the bits left in the shift register.
    logic [7:0]  shift_next;
    logic        new_bit;
    assign new_bit = is_one & ~is_zero;
    // LSB first enters at the top, MSB first at the bottom
    assign shift_next = high_q[IRR_HB_DIR] ? {shift_q[6:0], new_bit}
                                           : {new_bit, shift_q[7:1]};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_q   <= 8'h0;
            bit_cnt_q <= 3'h0;
            rx_data_q <= 8'h0;
        end else if (!run || guide_done || (start_edge && fmt == IRR_FMT_C)) begin
            // clear on first rise in format C
            shift_q   <= 8'h0;
            bit_cnt_q <= 3'h0;
        end else if (bit_ok) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
                rx_data_q <= shift_next;
                shift_q   <= 8'h0;
            end else begin
                shift_q   <= shift_next;
            end
        end
    end

endmodule

//--- tb/irr_receiver_sva.sv
`timescale 1ns/100ps
// Watches the register bus of the receiver from its ports alone.
module irr_receiver_sva
    import irr_pkg::*;
#(
    parameter int ADR_W = 18                   // Byte address width.
) (
    input wire logic             clk_i,        // System clock.
    input wire logic             rst_i,        // Synchronous reset.
    input wire logic             cyc_i,        // Bus cycle.
    input wire logic             stb_i,        // Bus strobe.
    input wire logic             we_i,         // Write enable.
    input wire logic [ADR_W-1:0] adr_i,        // Byte address.
    input wire logic [3:0]       sel_i,        // Byte selects.
    input wire logic [31:0]      dat_i,        // Write data.
    input wire logic [31:0]      dat_o,        // Read data.
    input wire logic             ack_o,        // Acknowledge.
    input wire logic             remote_i      // Remote input.
);
    logic [15:0] idx;                          // Register index.
    logic [1:0]  sub;                          // Low index bits pick a shadow.
    logic        rd_go;                        // A read is taken here.
    logic        wr_go;                        // A byte write is taken here.
    logic [7:0]  wid_q [4];                    // Shadows of width and high registers.
    assign idx   = 16'(adr_i[ADR_W-1:2]);
    assign sub   = idx[1:0];
    assign rd_go = cyc_i && stb_i && !we_i && !ack_o;
    assign wr_go = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    // Shadows follow each taken write, so readback needs no knowledge of the body.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wid_q <= '{default: 8'h00};
        end else if (wr_go && idx >= IRR_IDX_GUIDE && idx <= IRR_IDX_HIGH) begin
            wid_q[sub] <= dat_i[7:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing after a request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without a request");
    a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_data_holds: assert property (!rd_go |=> $stable(dat_o))
        else $error("read data moved without a read");
    a_width_back: assert property (rd_go && idx >= IRR_IDX_GUIDE && idx <= IRR_IDX_DATA1
        |=> dat_o[7:0] == wid_q[$past(sub)])
        else $error("width register readback wrong");
    a_high_back: assert property (rd_go && idx == IRR_IDX_HIGH
        |=> dat_o[7:0] == (wid_q[2] & 8'hbf))
        else $error("high bits readback wrong");
    a_unmapped_zero: assert property (rd_go && (idx < IRR_IDX_CTRL || idx > IRR_IDX_HIGH)
        |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    c_data_read: cover property (rd_go && idx == IRR_IDX_DATA);
    c_remote_rise: cover property ($rose(remote_i));
    c_high_write: cover property (wr_go && idx == IRR_IDX_HIGH);
endmodule

bind irr_receiver irr_receiver_sva #(.ADR_W(ADR_W)) i_sva (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .remote_i(remote_i));

//--- tb/irr_remote_model.sv
`timescale 1ns/100ps
// Remote source; the line rests low between frames, as a quiet receiver sees it.
module irr_remote_model
    import irr_pkg::*;
(
    input  wire logic clk_i,                   // System clock.
    output logic      remote_o                 // Demodulated remote level.
);
    int unit = 4;                              // Clocks per measurement unit.
    initial remote_o = 1'b0;
    // Holds a level for whole units; every change lands just after an edge.
    task automatic lvl(input logic v, input int u);
        remote_o <= v;
        repeat (u * unit) @(posedge clk_i);
    endtask
    // One frame: guide for A and B, data periods, a short bad period if asked, closing edge, silence.
    // guide shape per format
    task automatic frame(input logic [1:0] fmt, input int clocks, input int n,
                         input logic [15:0] pat, input logic bad);
        logic act;                             // Level after a measuring edge.
        int   k;
        int   p;
        unit = clocks;
        act  = (fmt != IRR_FMT_A);
        if (fmt == IRR_FMT_B) begin
            lvl(1'b1, 4);
            lvl(1'b0, 11);
        end else if (fmt == IRR_FMT_A) begin
            lvl(1'b1, 15);
        end
        for (k = 0; k < n + bad; k++) begin
            p = (k == n) ? 6 : (pat[k] ? 20 : 12);
            lvl(act, 4);
            lvl(!act, p - 4);
        end
        lvl(act, 4);
        lvl(1'b0, 40);
    endtask
endmodule

//--- tb/tb_irr_receiver.sv
`timescale 1ns/100ps
// Drives the receiver over classic Wishbone beside a modelled remote source.
module tb_irr_receiver;
    import irr_pkg::*;
    logic        clk_i    = 1'b0;              // System clock.
    logic        rst_i    = 1'b1;              // Synchronous reset.
    logic        cyc_i    = 1'b0;              // Bus cycle.
    logic        stb_i    = 1'b0;              // Bus strobe.
    logic        we_i     = 1'b0;              // Write enable.
    logic [17:0] adr_i    = 18'h0;             // Byte address.
    logic [3:0]  sel_i    = 4'h0;              // Byte selects.
    logic [31:0] dat_i    = 32'h0;             // Write data.
    logic [31:0] dat_o;                        // Read data.
    logic        ack_o;                        // Acknowledge.
    logic        remote;                       // Remote line from the model.
    int          failures = 0;                 // Mismatches seen.
    int          checks   = 0;                 // Comparisons made.
    logic [2:0]  ck       = 3'h0;              // Base clock select used by rx.
    // Half period of 2 ns gives 250 MHz.
    always #2 clk_i = ~clk_i;
    irr_receiver #(.ADR_W(18)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .remote_i(remote));
    irr_remote_model i_rc (.clk_i(clk_i), .remote_o(remote));
    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= 4'hf;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 50) begin
            failures++;
            $display("BAD ack expected 1 seen none");
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, idx, d, q);
    endtask
    // Reads a register and compares it with the value worked out here.
    task automatic rd(input logic [15:0] idx, input logic [7:0] e, input string nm);
        logic [7:0] q;
        wb(1'b0, idx, 8'h00, q);
        checks++;
        if (q !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, q);
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Configures, receives one frame, then checks flags, byte, count and partial byte.
    task automatic rx(input logic [1:0] fmt, input logic dir, input logic [1:0] pc,
                      input int n, input logic [15:0] pat, input logic bad);
        logic [7:0] sh;
        logic [7:0] dat;
        int         k;
        sh  = 8'h00;
        dat = 8'h00;
        wr(IRR_IDX_STATUS, 8'h0f);
        wr(IRR_IDX_CNTPR, {pc, pc, 4'h0});
        wr(IRR_IDX_HIGH, {dir, 7'h3a});
        wr(IRR_IDX_CTRL, {1'b0, ck, 1'b0, fmt, 1'b1});
        i_rc.frame(fmt, (4 << pc) << ck, n, pat, bad);
        for (k = 0; k < n; k++) begin
            sh = dir ? {sh[6:0], pat[k]} : {pat[k], sh[7:1]};
            if (k % 8 == 7) begin
                dat = sh;
                sh  = 8'h00;
            end
        end
        rd(IRR_IDX_STATUS, {4'h0, fmt != IRR_FMT_C, bad, n >= 8, !bad}, "status");
        if (n >= 8) rd(IRR_IDX_DATA, dat, "data");
        rd(IRR_IDX_CNTPR, {pc, pc, !bad, 3'(n)}, "count");
        if (!bad) rd(IRR_IDX_SHIFT, sh, "shift");
        rd(IRR_IDX_CNTPR, {pc, pc, 1'b0, 3'(n)}, "resume");
    endtask
    // Main sequence of scenarios.
    initial begin
        int i;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 9; i++) begin
            rd(IRR_IDX_CTRL + 16'(i), 8'h00, "reset");
        end
        wr(16'h0010, 8'hff);
        rd(16'h0010, 8'h00, "unmapped");
        wr(IRR_IDX_SHIFT, 8'h55);
        rd(IRR_IDX_SHIFT, 8'h00, "shift ro");
        wr(IRR_IDX_HIGH, 8'hff);
        rd(IRR_IDX_HIGH, 8'hbf, "high");
        // Windows of 10..20, 8..16 and 16..24 units, ordered and eight apart.
        wr(IRR_IDX_GUIDE, 8'h4a);
        wr(IRR_IDX_DATA0, 8'h08);
        wr(IRR_IDX_DATA1, 8'h80);
        rd(IRR_IDX_GUIDE, 8'h4a, "guide");
        rx(IRR_FMT_A, 1'b0, 2'h0, 11, 16'h05a5, 1'b0);
        rx(IRR_FMT_A, 1'b1, 2'h0, 8, 16'h00c3, 1'b0);
        rx(IRR_FMT_B, 1'b0, 2'h0, 10, 16'h0136, 1'b0);
        rx(IRR_FMT_B, 1'b1, 2'h0, 11, 16'h0659, 1'b0);
        rx(IRR_FMT_C, 1'b0, 2'h0, 9, 16'h01e1, 1'b0);
        rx(IRR_FMT_C, 1'b1, 2'h0, 13, 16'h1a2b, 1'b0);
        rx(IRR_FMT_A, 1'b0, 2'h0, 3, 16'h0005, 1'b1);
        rx(IRR_FMT_A, 1'b0, 2'h0, 2, 16'h0002, 1'b0);
        // A base select of one doubles the unit to eight clocks.
        ck = 3'h1;
        rx(IRR_FMT_A, 1'b0, 2'h0, 8, 16'h0096, 1'b0);
        ck = 3'h0;
        for (i = 0; i < 4; i++) begin
            rx(IRR_FMT_A, 1'b0, 2'(i), 8, 16'h0096, 1'b0);
        end
        // A suspended receiver ignores a second frame until run is cleared.
        wr(IRR_IDX_CNTPR, 8'h00);
        wr(IRR_IDX_STATUS, 8'h0f);
        i_rc.frame(IRR_FMT_A, 4, 5, 16'h0015, 1'b0);
        wr(IRR_IDX_STATUS, 8'h0f);
        i_rc.frame(IRR_FMT_A, 4, 8, 16'h00ff, 1'b0);
        rd(IRR_IDX_STATUS, 8'h00, "suspended");
        rd(IRR_IDX_CNTPR, 8'h0d, "held");
        wr(IRR_IDX_CTRL, 8'h00);
        rd(IRR_IDX_CNTPR, 8'h00, "run clear");
        rd(IRR_IDX_SHIFT, 8'h00, "shift clear");
        summarize();
    end
    // Tests take about 21000 cycles; this cuts a hang short well beyond that.
    initial begin
        repeat (90000) @(posedge clk_i);
        failures++;
        summarize();
    end
endmodule
